// [verilog/dcds_decode.sv]
`include "dcds_params.svh"

module dcds_decode
#(
    parameter int BANKS = 8,
    parameter int READ_BURST = 4
)
(
    input  wire logic                      ref_clk,
    input  wire logic                      resetn,
    input  wire dcds_pkg::dcds_cmd_pins_s  cmd_pins,
    input  wire dcds_pkg::dcds_strobe_cfg_s strobe_cfg,
    input  wire logic                      read_data_active,
    input  wire logic                      strobe_in,
    input  wire logic                      write_byte_mask,
    output dcds_pkg::dcds_cmd_s            cmd_q,
    output logic                           cmd_valid_q,
    output logic [BANKS-1:0]               bank_open_q,
    output logic                           strobe_out,
    output logic                           strobe_oe,
    output logic                           strobe_c_out,
    output logic                           strobe_c_oe,
    output logic                           read_only_strobe,
    output logic                           read_only_strobe_oe,
    output logic                           read_only_strobe_complement,
    output logic                           read_only_strobe_complement_oe,
    output logic                           write_strobe_sync,
    output logic                           write_mask_q
);
    import dcds_pkg::*;

    if (BANKS != 8)
    begin : g_bad_banks
        $error("BANKS must be 8 for a three-bit bank address");
    end
    if (READ_BURST < 1)
    begin : g_bad_burst
        $error("READ_BURST must be at least one");
    end

    // Command pins come off the memory bus clock, so synchronise them
    dcds_cmd_pins_s meta_q;
    dcds_cmd_pins_s pins_q;

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            meta_q <= '1;
            pins_q <= '1;
        end
        else
        begin
            meta_q <= cmd_pins;
            pins_q <= meta_q;
        end
    end

    wire logic [3:0] code = {pins_q.cs_n, pins_q.row_strobe_n,
                             pins_q.col_strobe_n, pins_q.write_en_n};
    wire logic       decoder_en = ~pins_q.cs_n;
    wire logic       is_act = (code == `DCDS_CODE_ACTIVATE);
    wire logic       is_pre = (code == `DCDS_CODE_PRECHARGE);
    wire logic       is_rd  = (code == `DCDS_CODE_READ);
    wire logic       is_wr  = (code == `DCDS_CODE_WRITE);

    dcds_cmd_e kind_d;
    always_comb
    begin
        if (!decoder_en)
            kind_d = DCDS_CMD_NONE;
        else if (is_act)
            kind_d = DCDS_CMD_ACTIVATE;
        else if (is_pre)
            kind_d = DCDS_CMD_PRECHARGE;
        else if (is_rd)
            kind_d = DCDS_CMD_READ;
        else if (is_wr)
            kind_d = DCDS_CMD_WRITE;
        else
            kind_d = DCDS_CMD_OTHER;
    end

    wire logic [BANKS-1:0] bank_sel = BANKS'(1) << pins_q.bank;
    logic [BANKS-1:0] bank_open_d;
    always_comb
    begin
        bank_open_d = bank_open_q;
        case (kind_d)
            DCDS_CMD_ACTIVATE:  bank_open_d = bank_open_q | bank_sel;
            DCDS_CMD_PRECHARGE: bank_open_d = bank_open_q & ~bank_sel;
            default:            bank_open_d = bank_open_q;
        endcase
    end

    dcds_cmd_s cmd_d;
    always_comb
    begin
        cmd_d.kind     = kind_d;
        cmd_d.bank     = pins_q.bank;
        cmd_d.column   = pins_q.addr[`DCDS_COL_MSB:`DCDS_COL_LSB];
        cmd_d.auto_pre = (is_rd | is_wr) & pins_q.addr[`DCDS_AUTO_PRE_BIT];
        cmd_d.row      = pins_q.addr;
    end

    // Latched once per rising edge of the true clock
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            cmd_q       <= '0;
            cmd_valid_q <= 1'b0;
            bank_open_q <= `DCDS_BANK_OPEN_RST;
        end
        else
        begin
            cmd_q       <= cmd_d;
            cmd_valid_q <= decoder_en;
            bank_open_q <= bank_open_d;
        end
    end

    // Device drives strobes only during reads
    wire logic drive_main = read_data_active;
    wire logic drive_read_only_strobe_complement = read_data_active & strobe_cfg.read_strobe_en;
    logic      mask_meta_q;
    logic      mask_sync_q;

    dcds_strobe_pin u_main
    (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .drive_en  (drive_main),
        .compl_en  (strobe_cfg.strobe_compl_en),
        .pin_in    (strobe_in),
        .pin_out   (strobe_out),
        .pin_oe    (strobe_oe),
        .pin_c_out (strobe_c_out),
        .pin_c_oe  (strobe_c_oe),
        .pin_sync  (write_strobe_sync)
    );

    dcds_strobe_pin u_read_only_strobe_complement
    (
        .ref_clk   (ref_clk),
        .resetn    (resetn),
        .drive_en  (drive_read_only_strobe_complement),
        .compl_en  (strobe_cfg.strobe_compl_en),
        .pin_in    (1'b0),
        .pin_out   (read_only_strobe),
        .pin_oe    (read_only_strobe_oe),
        .pin_c_out (read_only_strobe_complement),
        .pin_c_oe  (read_only_strobe_complement_oe),
        .pin_sync  ()
    );

    // Mask pin is an input only when the read strobe option is off
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            mask_meta_q  <= 1'b0;
            mask_sync_q  <= 1'b0;
            write_mask_q <= 1'b0;
        end
        else
        begin
            // Gate only after the second flop, so nothing else reads the first
            mask_meta_q  <= write_byte_mask;
            mask_sync_q  <= mask_meta_q;
            write_mask_q <= mask_sync_q & ~strobe_cfg.read_strobe_en;
        end
    end

    a_cs_masks: assert property (@(posedge ref_clk) disable iff (!resetn)
        pins_q.cs_n |=> (cmd_q.kind == DCDS_CMD_NONE) && !cmd_valid_q)
        else $error("command decoded with chip select high");

    a_act_opens: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!pins_q.cs_n && code == `DCDS_CODE_ACTIVATE) |=>
            bank_open_q[$past(pins_q.bank)] && cmd_q.kind == DCDS_CMD_ACTIVATE)
        else $error("activate did not open bank");

    a_pre_closes: assert property (@(posedge ref_clk) disable iff (!resetn)
        (code == `DCDS_CODE_PRECHARGE) |=>
            !bank_open_q[$past(pins_q.bank)] && cmd_q.kind == DCDS_CMD_PRECHARGE)
        else $error("precharge did not close bank");

    a_rd_decode: assert property (@(posedge ref_clk) disable iff (!resetn)
        (code == `DCDS_CODE_READ) |=> cmd_q.kind == DCDS_CMD_READ)
        else $error("read not decoded");

    a_wr_decode: assert property (@(posedge ref_clk) disable iff (!resetn)
        (code == `DCDS_CODE_WRITE) |=> cmd_q.kind == DCDS_CMD_WRITE)
        else $error("write not decoded");

    a_other_keeps: assert property (@(posedge ref_clk) disable iff (!resetn)
        (cmd_d.kind == DCDS_CMD_OTHER || cmd_d.kind == DCDS_CMD_NONE)
            |=> $stable(bank_open_q))
        else $error("bank state changed on other command");

    a_col_auto: assert property (@(posedge ref_clk) disable iff (!resetn)
        (is_rd || is_wr) |=> cmd_q.auto_pre == $past(pins_q.addr[10])
            && cmd_q.column == $past(pins_q.addr[9:0]))
        else $error("column or auto precharge wrong");

    a_strobe_dir: assert property (@(posedge ref_clk) disable iff (!resetn)
        strobe_oe == read_data_active)
        else $error("strobe driven outside reads");

    a_strobe_tog: assert property (@(posedge ref_clk) disable iff (!resetn)
        (read_data_active [*2]) |-> strobe_out != $past(strobe_out))
        else $error("read strobe missed an edge");

    a_read_only_strobe_complement_opt: assert property (@(posedge ref_clk) disable iff (!resetn)
        read_only_strobe_oe == (read_data_active && strobe_cfg.read_strobe_en))
        else $error("read strobe option misapplied");

    a_compl_en: assert property (@(posedge ref_clk) disable iff (!resetn)
        strobe_c_oe |-> strobe_cfg.strobe_compl_en && strobe_oe)
        else $error("complement strobe driven while disabled");
endmodule

// [verilog/dcds_params.svh]
`ifndef DCDS_PARAMS_SVH
`define DCDS_PARAMS_SVH

// Command code bit positions within {cs_n, row_strobe_n, col_strobe_n, write_en_n}
`define DCDS_CMD_CS_BIT       3
`define DCDS_CMD_ROW_BIT      2
`define DCDS_CMD_COL_BIT      1
`define DCDS_CMD_WE_BIT       0

// Command codes, all active low
`define DCDS_CODE_ACTIVATE    4'h3
`define DCDS_CODE_PRECHARGE   4'h2
`define DCDS_CODE_READ        4'h5
`define DCDS_CODE_WRITE       4'h4

// Column address and auto precharge positions
`define DCDS_COL_LSB          0
`define DCDS_COL_MSB          9
`define DCDS_AUTO_PRE_BIT     10

// Reset values
`define DCDS_BANK_OPEN_RST    8'h00

`endif

// [verilog/dcds_pkg.sv]
package dcds_pkg;

    typedef enum logic [2:0]
    {
        DCDS_CMD_NONE,
        DCDS_CMD_ACTIVATE,
        DCDS_CMD_PRECHARGE,
        DCDS_CMD_READ,
        DCDS_CMD_WRITE,
        DCDS_CMD_OTHER
    } dcds_cmd_e;

    typedef struct packed
    {
        logic        cs_n;
        logic        row_strobe_n;
        logic        col_strobe_n;
        logic        write_en_n;
        logic [2:0]  bank;
        logic [13:0] addr;
    } dcds_cmd_pins_s;

    typedef struct packed
    {
        dcds_cmd_e   kind;
        logic [2:0]  bank;
        logic [9:0]  column;
        logic        auto_pre;
        logic [13:0] row;
    } dcds_cmd_s;

    typedef struct packed
    {
        logic read_strobe_en;
        logic strobe_compl_en;
    } dcds_strobe_cfg_s;

endpackage

// [verilog/dcds_strobe_pin.sv]
`include "dcds_params.svh"

module dcds_strobe_pin
(
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic drive_en,
    input  wire logic compl_en,
    input  wire logic pin_in,
    output logic      pin_out,
    output logic      pin_oe,
    output logic      pin_c_out,
    output logic      pin_c_oe,
    output logic      pin_sync
);
    logic meta_q;
    logic sync_q;
    logic tog_q;

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            tog_q  <= 1'b0;
        end
        else
        begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            // Edge on every cycle while drive_en is high, so edges line up with data changes
            tog_q  <= drive_en ? ~tog_q : 1'b0;
        end
    end

    assign pin_out   = tog_q;
    assign pin_oe    = drive_en;
    assign pin_c_out = ~tog_q;
    assign pin_c_oe  = drive_en & compl_en;
    assign pin_sync  = sync_q;
endmodule

// [tb/dcds_ctrl_model.sv]
module dcds_ctrl_model
(
    input  wire logic                    ref_clk,
    input  wire dcds_pkg::dcds_cmd_pins_s req,
    input  wire logic                    mask_req,
    output dcds_pkg::dcds_cmd_pins_s     cmd_pins,
    output logic                         strobe_in,
    output logic                         write_byte_mask
);
    timeunit 1ns;
    timeprecision 1ps;
    import dcds_pkg::*;

    // Chip select travels with the command code
    assign cmd_pins        = req;
    assign write_byte_mask = mask_req;

    // Falling edge puts strobe edges mid data window; when released the
    // line keeps changing so a stale value can never pass
    always @(negedge ref_clk)
    begin
        strobe_in <= (strobe_in !== 1'b1);
    end
endmodule

// [tb/ddr2_command_decode_and_strobe_tb_top.sv]
module ddr2_command_decode_and_strobe_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dcds_pkg::*;

    localparam int LAT = 3;

    logic             ref_clk  = 1'b0;
    logic             resetn   = 1'b0;
    dcds_cmd_pins_s   req      = '1;
    dcds_strobe_cfg_s cfg      = '0;
    logic             rda      = 1'b0;
    logic             mask_req = 1'b0;
    dcds_cmd_pins_s   cmd_pins;
    logic             strobe_in;
    logic             write_byte_mask;
    dcds_cmd_s        cmd_q;
    logic             cmd_valid_q;
    logic [7:0]       bank_open_q;
    logic             strobe_out;
    logic             strobe_oe;
    logic             strobe_c_oe;
    logic             ro_oe;
    logic             ws_sync;
    logic             sc_out;
    logic             ro_out;
    logic             ro_c_out;
    logic             ro_c_oe;
    logic             wmask;
    integer           seed     = 32'hacab1517;
    int               fails    = 0;
    int               n_compared = 0;
    dcds_cmd_pins_s   hist[$];
    logic [7:0]       banks_m  = 8'h00;
    logic             sout_m   = 1'b0;
    logic [1:0]       sin_h    = 2'h0;
    logic             ro_m     = 1'b0;
    logic [1:0]       mh       = 2'h0;
    logic             wm_m     = 1'b0;
    logic [31:0]      r;
    dcds_cmd_pins_s   p;

    always #10 ref_clk = ~ref_clk;

    dcds_ctrl_model i_ctrl
    (
        .ref_clk         (ref_clk),
        .req             (req),
        .mask_req        (mask_req),
        .cmd_pins        (cmd_pins),
        .strobe_in       (strobe_in),
        .write_byte_mask (write_byte_mask)
    );

    dcds_decode i_dut
    (
        .ref_clk                        (ref_clk),
        .resetn                         (resetn),
        .cmd_pins                       (cmd_pins),
        .strobe_cfg                     (cfg),
        .read_data_active               (rda),
        .strobe_in                      (strobe_in),
        .write_byte_mask                (write_byte_mask),
        .cmd_q                          (cmd_q),
        .cmd_valid_q                    (cmd_valid_q),
        .bank_open_q                    (bank_open_q),
        .strobe_out                     (strobe_out),
        .strobe_oe                      (strobe_oe),
        .strobe_c_out                   (sc_out),
        .strobe_c_oe                    (strobe_c_oe),
        .read_only_strobe               (ro_out),
        .read_only_strobe_oe            (ro_oe),
        .read_only_strobe_complement    (ro_c_out),
        .read_only_strobe_complement_oe (ro_c_oe),
        .write_strobe_sync              (ws_sync),
        .write_mask_q                   (wmask)
    );

    always @(posedge ref_clk)
    begin
        sout_m <= resetn && rda && !sout_m;
        ro_m   <= resetn && rda && cfg.read_strobe_en && !ro_m;
        // Synchroniser flops are cleared by reset
        sin_h  <= resetn ? {sin_h[0], strobe_in} : 2'h0;
        mh     <= resetn ? {mh[0], write_byte_mask} : 2'h0;
        wm_m   <= resetn && mh[1] && !cfg.read_strobe_en;
    end

    function automatic dcds_cmd_e kind_of(input dcds_cmd_pins_s c);
        if (c.cs_n)
            return DCDS_CMD_NONE;
        case ({c.row_strobe_n, c.col_strobe_n, c.write_en_n})
            3'h3:    return DCDS_CMD_ACTIVATE;
            3'h2:    return DCDS_CMD_PRECHARGE;
            3'h5:    return DCDS_CMD_READ;
            3'h4:    return DCDS_CMD_WRITE;
            default: return DCDS_CMD_OTHER;
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic step(input dcds_cmd_pins_s c);
        dcds_cmd_pins_s e;
        dcds_cmd_e      k;
        @(negedge ref_clk);
        chk(strobe_out, sout_m);
        chk(strobe_oe, rda);
        chk(strobe_c_oe, rda & cfg.strobe_compl_en);
        chk(ro_oe, rda & cfg.read_strobe_en);
        chk(ws_sync, sin_h[1]);
        chk(sc_out, !sout_m);
        chk(ro_out, ro_m);
        chk(ro_c_out, !ro_m);
        chk(ro_c_oe, rda & cfg.read_strobe_en & cfg.strobe_compl_en);
        chk(wmask, wm_m);
        if (hist.size() == LAT)
        begin
            e = hist.pop_front();
            k = kind_of(e);
            if (k == DCDS_CMD_ACTIVATE)
                banks_m[e.bank] = 1'b1;
            if (k == DCDS_CMD_PRECHARGE)
                banks_m[e.bank] = 1'b0;
            chk(cmd_valid_q, !e.cs_n);
            chk(cmd_q.kind, k);
            chk(bank_open_q, banks_m);
            if (k != DCDS_CMD_NONE && k != DCDS_CMD_OTHER)
                chk(cmd_q.bank, e.bank);
            if (k == DCDS_CMD_READ || k == DCDS_CMD_WRITE)
                chk({cmd_q.auto_pre, cmd_q.column}, e.addr[10:0]);
            if (k == DCDS_CMD_ACTIVATE)
                chk(cmd_q.row, e.addr);
        end
        // Precharge of all banks is outside this block's scope
        if (kind_of(c) == DCDS_CMD_PRECHARGE)
            c.addr[10] = 1'b0;
        r        = $random(seed);
        req      = c;
        rda      = r[0] | r[1];
        cfg      = r[3:2];
        mask_req = r[4];
        hist.push_back(c);
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(negedge ref_clk);
        resetn = 1'b1;
        // Every code, chip select both ways, banks walking
        for (int c = 0; c < 128; c++)
        begin
            r = $random(seed);
            p = r[20:0];
            {p.cs_n, p.row_strobe_n, p.col_strobe_n, p.write_en_n} = c[3:0];
            p.bank = c[6:4];
            step(p);
        end
        $display("directed codes done");
        for (int n = 0; n < 800; n++)
        begin
            r = $random(seed);
            step(dcds_cmd_pins_s'(r[20:0]));
        end
        for (int n = 0; n < LAT; n++)
            step('1);
        $display("random traffic done");
        report_and_stop();
    end
endmodule
